// ==== logic/spc_top.sv ====
`timescale 1ns/1ps
module spc_top
    import spc_pkg::*;
#(
    parameter int unsigned WIDTH = WORD_BITS,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             rate_clock_source_select,
    input  wire logic [7:0]       bit_clock_divide_value,
    input  wire logic             tx_output_early_enable,
    input  wire logic [1:0]       tx_data_delay,
    input  wire logic [1:0]       clock_stop_mode,
    input  wire logic             tx_clock_polarity,
    input  wire logic             rx_clock_polarity,
    input  wire logic             tx_sync_polarity,
    input  wire logic             rx_sync_polarity,
    input  wire logic             tx_clock_direction,
    input  wire logic             rx_clock_direction,
    input  wire logic             tx_sync_direction,
    input  wire logic             rx_sync_direction,
    input  wire logic             rate_clock_pin,
    input  wire logic [WIDTH-1:0] tx_word,
    input  wire logic             tx_word_valid,
    output logic                  tx_word_ready,
    output logic      [WIDTH-1:0] rx_word,
    output logic                  rx_word_valid,
    input  wire logic             transmit_bit_clock_in,
    output logic                  transmit_bit_clock_out,
    output logic                  transmit_bit_clock_oe,
    input  wire logic             receive_bit_clock_in,
    input  wire logic             transmit_frame_sync_in,
    output logic                  transmit_frame_sync_out,
    output logic                  transmit_frame_sync_oe,
    input  wire logic             receive_frame_sync_in,
    output logic                  serial_data_out,
    output logic                  serial_data_out_oe,
    input  wire logic             serial_data_in,
    output logic                  busy
);
    localparam int unsigned BW = $clog2(WIDTH + 1);

    spc_div_if div ();

    spc_state_e       state;
    logic [WIDTH-1:0] fifo_data;
    logic             fifo_valid;
    logic             fifo_pop;
    logic [WIDTH-1:0] tx_shift;
    logic [WIDTH-1:0] rx_shift;
    logic [BW-1:0]    bit_cnt;
    logic             sel_act;
    logic             sel_pin;
    logic             clk_en;
    logic [3:0]       early_cnt;
    logic             pend_bit;
    logic             launch_first;
    logic             launch_next;
    logic             sample_ev;
    logic             master_mode;
    logic             slave_mode;
    logic             spi_on;
    logic             start;
    logic             last_sample;
    logic             tclk_q;
    logic             rclk_q;
    logic             ssel_q;
    logic             tclk_int;
    logic             rclk_int;
    logic             slave_sel;

    ////////////////////////////////////////////////////////////////////////////
    // rate and bit clock generation, and the transmit word fifo
    assign div.divide     = bit_clock_divide_value;
    assign div.source_cpu = rate_clock_source_select;

    spc_clkgen u_clkgen (
        .sys_clk        (sys_clk),
        .rst_b          (rst_b),
        .rate_clock_pin (rate_clock_pin),
        .div            (div)
    );

    spc_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .in_data   (tx_word),
        .in_valid  (tx_word_valid),
        .in_ready  (tx_word_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////////////
    // role decode; software sets directions and rate per role
    assign spi_on      = (clock_stop_mode == CLKSTOP_NODELAY);
    assign master_mode = spi_on && tx_clock_direction && tx_sync_direction
                         && !rx_clock_direction && !rx_sync_direction;
    assign slave_mode  = spi_on && !tx_clock_direction && !tx_sync_direction
                         && !rx_clock_direction && !rx_sync_direction;

    // slave pins: polarity one turns the incoming active-low levels round
    assign tclk_int  = transmit_bit_clock_in ^ tx_clock_polarity;
    assign rclk_int  = receive_bit_clock_in ^ rx_clock_polarity;
    assign slave_sel = (transmit_frame_sync_in ^ tx_sync_polarity)
                       && (receive_frame_sync_in ^ rx_sync_polarity);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tclk_q <= 1'b0;
            rclk_q <= 1'b0;
            ssel_q <= 1'b0;
        end else begin
            tclk_q <= tclk_int;
            rclk_q <= rclk_int;
            ssel_q <= slave_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // launch and sample events for both roles
    assign last_sample = (bit_cnt == BW'(WIDTH - 1));
    assign start       = master_mode && (state == SPC_IDLE) && fifo_valid && div.fall;
    assign fifo_pop    = start || (slave_mode && slave_sel && !ssel_q && fifo_valid);

    always_comb begin
        launch_first = 1'b0;
        launch_next  = 1'b0;
        sample_ev    = 1'b0;
        if (master_mode) begin
            launch_first = start ? (tx_data_delay == DATDLY_ZERO)
                         : ((state == SPC_LEAD) && div.rise
                            && (tx_data_delay != DATDLY_ZERO));
            launch_next  = (state == SPC_SHIFT) && div.rise;
            sample_ev    = (state == SPC_SHIFT) && div.fall;
        end else if (slave_mode) begin
            launch_first = slave_sel && !ssel_q;
            launch_next  = slave_sel && tclk_int && !tclk_q && (bit_cnt != '0);
            sample_ev    = slave_sel && !rclk_int && rclk_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // master framing sequence
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state   <= SPC_IDLE;
            sel_act <= 1'b0;
            clk_en  <= 1'b0;
        end else begin
            case (state)
                SPC_IDLE: begin
                    if (start) begin
                        sel_act <= 1'b1;
                        state   <= SPC_LEAD;
                    end
                end
                SPC_LEAD: begin
                    if (div.rise) begin
                        clk_en <= 1'b1;
                        state  <= SPC_SHIFT;
                    end
                end
                SPC_SHIFT: begin
                    if (div.fall && last_sample) begin
                        clk_en <= 1'b0;
                        state  <= SPC_TRAIL;
                    end
                end
                SPC_TRAIL: begin
                    if (div.fall) begin
                        sel_act <= 1'b0;
                        state   <= SPC_IDLE;
                    end
                end
                default: begin
                    state   <= SPC_IDLE;
                    sel_act <= 1'b0;
                    clk_en  <= 1'b0;
                end
            endcase
            if (!master_mode) begin
                state   <= SPC_IDLE;
                sel_act <= 1'b0;
                clk_en  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shift registers and received word
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_shift      <= '0;
            rx_shift      <= '0;
            bit_cnt       <= '0;
            rx_word       <= '0;
            rx_word_valid <= 1'b0;
        end else begin
            rx_word_valid <= 1'b0;
            if (fifo_pop) begin
                tx_shift <= fifo_data;
                bit_cnt  <= '0;
            end else if (slave_mode && slave_sel && !ssel_q) begin
                tx_shift <= '0;
                bit_cnt  <= '0;
            end else if (launch_next) begin
                tx_shift <= {tx_shift[WIDTH-2:0], 1'b0};
            end
            if (sample_ev) begin
                rx_shift <= {rx_shift[WIDTH-2:0], serial_data_in};
                bit_cnt  <= last_sample ? '0 : bit_cnt + 1'b1;
                if (last_sample) begin
                    rx_word       <= {rx_shift[WIDTH-2:0], serial_data_in};
                    rx_word_valid <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data pin; the early delay acts on the first bit of a word only
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            serial_data_out    <= 1'b0;
            serial_data_out_oe <= 1'b0;
            early_cnt          <= 4'h0;
            pend_bit           <= 1'b0;
        end else begin
            if (early_cnt != 4'h0) begin
                early_cnt <= early_cnt - 4'h1;
                if (early_cnt == 4'h1) begin
                    serial_data_out <= pend_bit;
                end
            end
            if (launch_first) begin
                serial_data_out_oe <= 1'b1;
                if (tx_output_early_enable) begin
                    early_cnt <= EARLY_CNT;
                    pend_bit  <= fifo_pop ? fifo_data[WIDTH-1] : tx_shift[WIDTH-1];
                end else begin
                    serial_data_out <= fifo_pop ? fifo_data[WIDTH-1] : tx_shift[WIDTH-1];
                end
            end else if (launch_next) begin
                serial_data_out <= tx_shift[WIDTH-2];
            end
            if (master_mode && state == SPC_TRAIL && div.rise) begin
                serial_data_out_oe <= 1'b0;
            end
            if (slave_mode && !slave_sel && ssel_q) begin
                serial_data_out_oe <= 1'b0;
            end
            if (!master_mode && !slave_mode) begin
                serial_data_out_oe <= 1'b0;
                early_cnt          <= 4'h0;
            end
        end
    end

    // select follows the divider pulses directly so lead and trail are whole phases
    assign sel_pin = (sel_act && !(state == SPC_TRAIL && div.fall)) || start;

    // clock stopped at the tx_clock_polarity level between words; the first high phase must not lose a cycle
    assign transmit_bit_clock_out  = ((clk_en || (state == SPC_LEAD && div.rise)) && div.level)
                                     ^ tx_clock_polarity;
    assign transmit_bit_clock_oe   = master_mode;
    assign transmit_frame_sync_out = sel_pin ^ tx_sync_polarity;
    assign transmit_frame_sync_oe  = master_mode;
    assign busy                    = (state != SPC_IDLE) || (slave_mode && slave_sel);

    ////////////////////////////////////////////////////////////////////////////
    property p_select_level;
        @(posedge sys_clk) disable iff (!rst_b)
        master_mode |-> transmit_frame_sync_out == (sel_pin ^ tx_sync_polarity);
    endproperty
    a_select_level: assert property (p_select_level) else $error("select level wrong");

    property p_lead;
        @(posedge sys_clk) disable iff (!rst_b)
        (start && master_mode) |=> sel_act && !clk_en until_with (div.rise || !master_mode);
    endproperty
    a_lead: assert property (p_lead) else $error("clock ran before select");

    property p_lead_bound;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == SPC_LEAD && div.rise && master_mode) |=> clk_en && state == SPC_SHIFT;
    endproperty
    a_lead_bound: assert property (p_lead_bound) else $error("no clock after lead");

    property p_trail;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == SPC_TRAIL && div.fall && master_mode) |=> !sel_act && state == SPC_IDLE;
    endproperty
    a_trail: assert property (p_trail) else $error("select not released");

    property p_trail_hold;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == SPC_SHIFT && div.fall && last_sample && master_mode)
            |=> sel_act && !div.fall;
    endproperty
    a_trail_hold: assert property (p_trail_hold) else $error("select dropped early");

    property p_float_master;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == SPC_TRAIL && div.rise && master_mode) |=> !serial_data_out_oe && sel_act;
    endproperty
    a_float_master: assert property (p_float_master) else $error("data not floated");

    property p_float_slave;
        @(posedge sys_clk) disable iff (!rst_b)
        (slave_mode && !slave_sel && ssel_q) |=> !serial_data_out_oe;
    endproperty
    a_float_slave: assert property (p_float_slave) else $error("slave data not floated");

    property p_datdly;
        @(posedge sys_clk) disable iff (!rst_b)
        (start && !serial_data_out_oe) |=> serial_data_out_oe == (tx_data_delay == DATDLY_ZERO);
    endproperty
    a_datdly: assert property (p_datdly) else $error("first bit timing wrong");

    property p_early;
        @(posedge sys_clk) disable iff (!rst_b)
        (launch_first && tx_output_early_enable && master_mode && !launch_next)
            |=> (early_cnt != 4'h0) [*5] ##1 (early_cnt == 4'h1);
    endproperty
    a_early: assert property (p_early) else $error("early delay length wrong");
endmodule : spc_top

// ==== logic/spc_pkg.sv ====
package spc_pkg;
    // one rate period is this many cpu cycles when the cpu quarter is the source
    localparam int unsigned RATE_DIV_CYC    = 4;
    // early output enable moves the first bit out by 4 to 8 cpu periods
    localparam int unsigned EARLY_MIN_CYC   = 4;
    localparam int unsigned EARLY_MAX_CYC   = 8;
    localparam int unsigned EARLY_CYC       = (EARLY_MIN_CYC + EARLY_MAX_CYC) / 2;
    localparam logic [3:0]  EARLY_CNT       = 4'(EARLY_CYC);
    localparam logic [1:0]  CLKSTOP_NODELAY = 2'h2;
    localparam logic [1:0]  DATDLY_ZERO     = 2'h0;
    localparam logic [7:0]  DIVIDE_RESET    = 8'h01;
    localparam int unsigned WORD_BITS       = 8;
    localparam int unsigned FIFO_DEPTH      = 8;

    typedef enum logic [1:0] {
        SPC_IDLE  = 2'h0,
        SPC_LEAD  = 2'h1,
        SPC_SHIFT = 2'h2,
        SPC_TRAIL = 2'h3
    } spc_state_e;
endpackage : spc_pkg

// ==== logic/spc_div_if.sv ====
`timescale 1ns/1ps
interface spc_div_if;
    logic [7:0] divide;
    logic       source_cpu;
    logic       level;
    logic       rise;
    logic       fall;

    modport gen (
        input  divide,
        input  source_cpu,
        output level,
        output rise,
        output fall
    );
    modport use_side (
        output divide,
        output source_cpu,
        input  level,
        input  rise,
        input  fall
    );
endinterface : spc_div_if

// ==== logic/spc_fifo.sv ====
`timescale 1ns/1ps
module spc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : spc_fifo

// ==== logic/spc_clkgen.sv ====
`timescale 1ns/1ps
module spc_clkgen
    import spc_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic rate_clock_pin,
    spc_div_if.gen    div
);
    logic [2:0] quarter_cnt;
    logic       pin_q;
    logic       rate_tick;
    logic [8:0] high_len;
    logic [8:0] low_len;
    logic [8:0] phase_cnt;
    logic       phase_done;
    logic       even_nz;

    // cpu quarter or rising edge of the external rate pin
    assign rate_tick = div.source_cpu ? (quarter_cnt == 3'(RATE_DIV_CYC - 1))
                                      : (rate_clock_pin && !pin_q);
    assign even_nz   = !div.divide[0] && (div.divide != 8'h00);
    // a zero divide would need half a rate period; it is held at one period per phase
    assign high_len  = even_nz ? {1'b0, div.divide[7:1]} + 9'h001
                               : ({1'b0, div.divide} + 9'h001) >> 1;
    assign low_len   = even_nz ? {1'b0, div.divide[7:1]}
                               : ({1'b0, div.divide} + 9'h001) >> 1;
    assign phase_done = (phase_cnt + 9'h001) >= (div.level ? high_len
                        : ((low_len == 9'h000) ? 9'h001 : low_len));

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            quarter_cnt <= 3'h0;
            pin_q       <= 1'b0;
        end else begin
            quarter_cnt <= (quarter_cnt == 3'(RATE_DIV_CYC - 1)) ? 3'h0 : quarter_cnt + 3'h1;
            pin_q       <= rate_clock_pin;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_cnt <= 9'h000;
            div.level <= 1'b0;
            div.rise  <= 1'b0;
            div.fall  <= 1'b0;
        end else begin
            div.rise <= rate_tick && phase_done && !div.level;
            div.fall <= rate_tick && phase_done && div.level;
            if (rate_tick) begin
                if (phase_done) begin
                    phase_cnt <= 9'h000;
                    div.level <= !div.level;
                end else begin
                    phase_cnt <= phase_cnt + 9'h001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checking helpers: cycles per period and per phase with a steady setting
    logic [11:0] per_cnt;
    logic [11:0] hi_cnt;
    logic [11:0] lo_cnt;
    logic [2:0]  settled;
    logic [7:0]  div_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            per_cnt <= 12'h000;
            hi_cnt  <= 12'h000;
            lo_cnt  <= 12'h000;
            settled <= 3'h0;
            div_q   <= 8'h00;
        end else begin
            div_q   <= div.divide;
            per_cnt <= div.rise ? 12'h001 : per_cnt + 12'h001;
            hi_cnt  <= div.rise ? 12'h001 : hi_cnt + 12'h001;
            lo_cnt  <= div.fall ? 12'h001 : lo_cnt + 12'h001;
            if (div_q != div.divide || !div.source_cpu) begin
                settled <= 3'h0;
            end else if (div.rise && settled != 3'h7) begin
                settled <= settled + 3'h1;
            end
        end
    end

    property p_rate_quarter;
        @(posedge sys_clk) disable iff (!rst_b)
        div.source_cpu && rate_tick |=> !rate_tick [*3] ##1 (rate_tick || !div.source_cpu);
    endproperty
    a_rate_quarter: assert property (p_rate_quarter) else $error("rate tick not every 4");

    property p_period;
        @(posedge sys_clk) disable iff (!rst_b)
        (div.rise && settled >= 3'h2 && div.divide != 8'h00)
            |-> per_cnt == 12'(({4'h0, div.divide} + 12'h001) * RATE_DIV_CYC);
    endproperty
    a_period: assert property (p_period) else $error("bit clock period wrong");

    property p_high;
        @(posedge sys_clk) disable iff (!rst_b)
        (div.fall && settled >= 3'h2) |-> hi_cnt == 12'({3'h0, high_len} * RATE_DIV_CYC);
    endproperty
    a_high: assert property (p_high) else $error("high phase length wrong");

    property p_low;
        @(posedge sys_clk) disable iff (!rst_b)
        (div.rise && settled >= 3'h2 && div.divide != 8'h00)
            |-> lo_cnt == 12'({3'h0, low_len} * RATE_DIV_CYC);
    endproperty
    a_low: assert property (p_low) else $error("low phase length wrong");
endmodule : spc_clkgen

// ==== verification/spc_peer.sv ====
`timescale 1ns/1ps
// far-side slave: launches on the rising clock, samples on the falling one
module spc_peer (
    input  wire logic       sel_b,
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic [7:0] reply,
    output logic            miso,
    output logic      [7:0] got
);
    logic [7:0] sh;
    initial miso = 1'b0;
    always @(negedge sel_b) sh = reply;
    always @(posedge sclk) if (!sel_b) begin
        miso <= sh[7];
        sh <= sh << 1;
    end
    always @(negedge sclk) if (!sel_b) got <= {got[6:0], mosi};
    // a released line shows the inverse, so a stale bit cannot pass for data
    always @(posedge sel_b) miso <= ~miso;
endmodule : spc_peer

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import spc_pkg::*;
    logic       sys_clk = 0, rst_b = 0, src = 1, early = 0, rpin = 0, valid = 0, z = 0, m = 1;
    logic [1:0] ddly = 2'h0, rc = 2'h0;
    logic [7:0] g = 8'h01, word = 8'h00, reply, rxw, got, r2;
    logic       ready, rxv, sck, sel, dout, doe, din, busy, pck = 0, psel = 1;
    logic [7:0] txq[$], rxq[$], sw;
    logic       sm = 0, ssck = 0, ssel = 1, mdat = 0;
    int         errors = 0, total_checks = 0, cycles = 0, cnt = 0, sp = 4, seed = 32'he5c8, i, n;
    always #10 sys_clk = ~sys_clk;
    spc_top i_spc_top (.sys_clk(sys_clk), .rst_b(rst_b), .rate_clock_source_select(src),
        .bit_clock_divide_value(g), .tx_output_early_enable(early), .tx_data_delay(ddly),
        .clock_stop_mode(2'h2), .tx_clock_polarity(z), .rx_clock_polarity(z),
        .tx_sync_polarity(m), .rx_sync_polarity(m), .tx_clock_direction(m && !sm),
        .rx_clock_direction(z), .tx_sync_direction(m && !sm), .rx_sync_direction(z),
        .rate_clock_pin(rpin), .tx_word(word), .tx_word_valid(valid), .tx_word_ready(ready),
        .rx_word(rxw), .rx_word_valid(rxv), .transmit_bit_clock_in(ssck),
        .transmit_bit_clock_out(sck), .transmit_bit_clock_oe(), .receive_bit_clock_in(ssck),
        .transmit_frame_sync_in(ssel), .transmit_frame_sync_out(sel),
        .transmit_frame_sync_oe(), .receive_frame_sync_in(ssel), .serial_data_out(dout),
        .serial_data_out_oe(doe), .serial_data_in(sm ? mdat : din), .busy(busy));
    spc_peer i_spc_peer (.sel_b(sel), .sclk(sck), .mosi(dout), .reply(reply), .miso(din),
        .got(got));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task print_verdict;
        $display("errors %0d checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    function int ph(input int gv, input int high);
        return gv[0] ? (gv + 1) / 2 : gv / 2 + high;
    endfunction : ph
    ////////////////////////////////////////////////////////////////////////////////////////
    // external rate clock: six system cycles a period
    always @(posedge sys_clk) begin
        rc <= (rc == 2'h2) ? 2'h0 : rc + 2'h1;
        if (rc == 2'h2) rpin <= ~rpin;
        if (++cycles == 60000) begin
            errors++;
            print_verdict;
        end
    end
    // phase lengths are timed only inside frames, where the clock may move
    always @(posedge sys_clk) begin
        pck <= sck;
        psel <= sel;
        cnt <= (sck != pck || (psel && !sel)) ? 1 : cnt + 1;
        if (!sel && sck && !pck) check(8'(cnt), 8'(ph(g, 0) * sp));
        if (!sel && !sck && pck) check(8'(cnt), 8'(ph(g, 1) * sp));
        if (sel && !psel) begin
            check(got, txq.pop_front());
            check({7'h0, doe}, 8'h00);
            check(8'(cnt), 8'((g + 1) * sp));
            r2 = $random(seed);
            reply <= r2;
            rxq.push_back(r2);
        end
        if (rxv) check(rxw, rxq.pop_front());
    end
    initial begin
        reply = $random(seed);
        rxq.push_back(reply);
        repeat (20) @(posedge sys_clk);
        rst_b <= 1;
        for (i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            src <= (i < 4);
            g <= (i < 4) ? 8'(i + 1) : 8'h01;
            sp = (i < 4) ? 4 : 6;
            ddly <= 2'(i);
            early <= i[0];
            repeat (3) begin
                @(posedge sys_clk);
                r2 = $random(seed);
                word <= r2;
                valid <= 1;
                txq.push_back(r2);
            end
            @(posedge sys_clk);
            valid <= 0;
            n = 0;
            while ((txq.size() != 0 || busy !== 1'b0) && n < 9000) begin
                @(posedge sys_clk);
                n++;
            end
        end
        // slave role: the bench plays the master on the clock and select inputs
        @(posedge sys_clk);
        sm <= 1;
        src <= 1;
        g <= 8'h01;
        rxq.delete();
        r2 = $random(seed);
        sw = $random(seed);
        word <= r2;
        valid <= 1;
        rxq.push_back(sw);
        @(posedge sys_clk);
        valid <= 0;
        repeat (4) @(posedge sys_clk);
        ssel <= 0;
        for (i = 7; i >= 0; i--) begin
            repeat (4) @(posedge sys_clk);
            ssck <= 1;
            mdat <= sw[i];
            repeat (4) @(posedge sys_clk);
            ssck <= 0;
            check({7'h0, dout}, {7'h0, r2[i]});
        end
        repeat (4) @(posedge sys_clk);
        ssel <= 1;
        repeat (4) @(posedge sys_clk);
        check({7'h0, doe}, 8'h00);
        print_verdict;
    end
endmodule : testbench
